// File: bss_sort_select.v
// beacon sort-select and termination sequencer of the sort-symbols instruction
// How it works
// - first input address comes from register 9
// - header bit 0 clear: code 3, end
// - header word kept in header hold register
// - altitude key equals mask: fetch word 5
// - no altitude match: AND type bits, mask
// - nothing selected: reject, read next header
// - any type match sends coordinates to filter
// - broadcast select: read words 3,4, pick word
// - index bits choose byte, then one bit
// - zero index bit rejects, nonzero sends on
// - end on count zero, interrupt, overflow
// - data stored at end gives code 1
// - base written back with flag bits cleared
// - input address minus 8 into register 9
// - registers 12, 13 reloaded from work area
// - header and K stored to work area
// - interrupts tested after every beacon record
// - I/O or external: address -8, counter -2
// - overflow: fetch next, bin number, code 2
`timescale 1ns/1ns
`include "bss_regs.vh"
module bss_sort_select (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // instruction start and control registers
  input  wire        start,
  input  wire [3:0]  r1_field,
  input  wire [23:0] instr_counter_in,
  input  wire [31:0] gpr8_in,
  input  wire [31:0] gpr9_in,
  input  wire [31:0] gpr10_in,
  input  wire [31:0] gpr11_in,
  input  wire [31:0] k_data,
  // interrupt and overflow events
  input  wire        irq_pend,
  input  wire        irq_program,
  input  wire        bin_ovf,
  input  wire [3:0]  bin_num,
  // storage read port
  output reg         rd_req_q,
  output reg  [23:0] rd_addr_q,
  input  wire        rd_ack,
  input  wire [63:0] rd_data,
  // storage write port
  output reg         st_req_q,
  output reg  [23:0] st_addr_q,
  output reg  [31:0] st_data_q,
  input  wire        st_ack,
  // coordinates to the geographic filter
  output reg         fl_valid_q,
  output reg  [31:0] fl_data_q,
  input  wire        fl_ready,
  // results
  output reg         busy_q,
  output reg         done_q,
  output reg  [1:0]  cc_q,
  output reg  [31:0] header_hold_register,
  output reg  [31:0] gpr8_q,
  output reg  [31:0] gpr9_q,
  output reg  [31:0] gpr12_q,
  output reg  [31:0] gpr13_q,
  output reg  [23:0] instruction_counter,
  output reg         gpr_wr_q
);
  localparam S_IDLE = 4'h0;
  localparam S_RD   = 4'h1;
  localparam S_HDR  = 4'h2;
  localparam S_IDX  = 4'h3;
  localparam S_PUSH = 4'h4;
  localparam S_NXT  = 4'h5;
  localparam S_REST = 4'h6;
  localparam S_ST1  = 4'h7;
  localparam S_ST2  = 4'h8;
  localparam S_FIN  = 4'h9;
  reg [3:0]  state_q;
  reg [2:0]  rsel_q;
  reg [23:0] addr_q;
  reg [23:0] base_q;
  reg [15:0] cnt_q;
  reg [31:0] b_q;
  reg [31:0] crd_q;
  reg [6:0]  idx_q;
  reg [2:0]  byte_select_counter;
  reg        need_idx_q;
  reg        ovf_q;
  reg [3:0]  ovf_bin_q;
  reg        ovf_end_q;
  reg        bad_q;
  reg [7:0]  g8_hi_q;
  reg [7:0]  g9_hi_q;
  // second buffer slot behind the output register
  reg        tail_v_q;
  reg [31:0] tail_q;
  // big-endian bit i of a word, bit 0 being the msb
  function bit_of;
    input [31:0] w;
    input [4:0]  i;
    begin
      bit_of = w[5'd31 - i];
    end
  endfunction
  // selected index bit, zeros forced into the other adder positions
  function adder_result_latch;
    input [31:0] w;
    input [1:0]  byte_sel;
    input [2:0]  bit_sel;
    reg   [7:0]  by;
    reg   [7:0]  bit_select_decode_order;
    begin
      by = w[8'd31 - {byte_sel, 3'h0} -: 8];
      bit_select_decode_order = 8'h80 >> bit_sel;
      adder_result_latch = |(by & bit_select_decode_order);
    end
  endfunction
  wire [7:0] alt_key   = header_hold_register[15:8];
  wire [7:0] alt_mask  = gpr11_in[23:16];
  wire [2:0] type_hit  = header_hold_register[23:21] & gpr11_in[15:13];
  wire       broadcast_select_bit = bit_of(header_hold_register, `BSS_BCAST_POS);
  wire [31:0] idx_word = (idx_q[6:5] == 2'h0) ? b_q :
                         (idx_q[6:5] == 2'h1) ? rd_data[63:32] : rd_data[31:0];
  wire       idx_hit   = adder_result_latch(idx_word, byte_select_counter[1:0], idx_q[2:0]);
  wire       push      = (state_q == S_PUSH) && !tail_v_q;
  ////////////////////////////////////////////////////////////////////////////////
  // two-entry buffer; a full second slot holds the sequencer in the push state
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fl_valid_q <= 1'b0;
      fl_data_q  <= 32'h00000000;
      tail_v_q   <= 1'b0;
      tail_q     <= 32'h00000000;
    end else begin
      if (!fl_valid_q || fl_ready) begin
        if (tail_v_q) begin
          fl_data_q  <= tail_q;
          fl_valid_q <= 1'b1;
          tail_v_q   <= push;
          tail_q     <= crd_q;
        end else begin
          fl_valid_q <= push;
          fl_data_q  <= push ? crd_q : fl_data_q;
        end
      end else if (push) begin
        tail_v_q <= 1'b1;
        tail_q   <= crd_q;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // instruction sequencer
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      rsel_q <= `BSS_RD_HDR;
      addr_q <= 24'h000000;
      base_q <= 24'h000000;
      cnt_q <= 16'h0000;
      b_q <= 32'h00000000;
      crd_q <= 32'h00000000;
      idx_q <= 7'h00;
      byte_select_counter <= 3'h0;
      need_idx_q <= 1'b0;
      ovf_q <= 1'b0;
      ovf_bin_q <= 4'h0;
      ovf_end_q <= 1'b0;
      bad_q <= 1'b0;
      g8_hi_q <= 8'h00;
      g9_hi_q <= 8'h00;
      rd_req_q <= 1'b0;
      rd_addr_q <= 24'h000000;
      st_req_q <= 1'b0;
      st_addr_q <= 24'h000000;
      st_data_q <= 32'h00000000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cc_q <= `BSS_CC_NONE;
      header_hold_register <= 32'h00000000;
      gpr8_q <= 32'h00000000;
      gpr9_q <= 32'h00000000;
      gpr12_q <= 32'h00000000;
      gpr13_q <= 32'h00000000;
      instruction_counter <= 24'h000000;
      gpr_wr_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      gpr_wr_q <= 1'b0;
      // overflow is sticky; a new event wins over the clear at start
      if (bin_ovf) begin
        ovf_q <= 1'b1;
        ovf_bin_q <= bin_num;
      end else if (start && state_q == S_IDLE)
        ovf_q <= 1'b0;
      case (state_q)
        S_IDLE: begin // only beacon input is handled here; other codes are ignored
          if (start && r1_field == `BSS_R1_BEACON) begin
            busy_q <= 1'b1;
            cc_q <= `BSS_CC_NONE;
            bad_q <= 1'b0;
            ovf_end_q <= 1'b0;
            addr_q <= gpr9_in[23:0];
            g9_hi_q <= gpr9_in[31:24];
            g8_hi_q <= gpr8_in[31:24];
            base_q <= gpr8_in[23:0];
            cnt_q <= gpr10_in[15:0];
            instruction_counter <= instr_counter_in;
            idx_q <= gpr11_in[30:24];
            rsel_q <= `BSS_RD_HDR;
            rd_req_q <= 1'b1;
            rd_addr_q <= gpr9_in[23:0];
            state_q <= S_RD;
          end
        end
        S_RD: begin
          if (rd_ack) begin
            rd_req_q <= 1'b0;
            if (rsel_q != `BSS_RD_REST) begin
              addr_q <= addr_q + `BSS_DW_STEP;
              cnt_q <= cnt_q - 16'h0001;
            end
            case (rsel_q)
              `BSS_RD_HDR: begin
                header_hold_register <= rd_data[63:32];
                b_q <= rd_data[31:0];
                state_q <= S_HDR;
              end
              `BSS_RD_IDX: begin
                if (!need_idx_q || idx_hit) begin
                  rsel_q <= `BSS_RD_CRD;
                  rd_req_q <= 1'b1;
                  rd_addr_q <= addr_q + `BSS_DW_STEP;
                end else begin
                  state_q <= S_NXT;
                end
              end
              `BSS_RD_CRD: begin
                crd_q <= rd_data[63:32];
                state_q <= S_PUSH;
              end
              `BSS_RD_PAGE: begin
                ovf_end_q <= 1'b1;
                state_q <= S_REST;
              end
              `BSS_RD_REST: begin
                gpr12_q <= rd_data[63:32];
                gpr13_q <= rd_data[31:0];
                st_req_q <= 1'b1;
                st_addr_q <= base_q + `BSS_WORK_OFS;
                st_data_q <= header_hold_register;
                state_q <= S_ST1;
              end
              default: state_q <= S_REST;
            endcase
          end
        end
        S_HDR: begin
          byte_select_counter <= idx_q[5:3];
          if (!bit_of(header_hold_register, 5'd0)) begin
            bad_q <= 1'b1;
            state_q <= S_FIN;
          end else if (alt_key == alt_mask || |type_hit) begin
            need_idx_q <= 1'b0;
            state_q <= S_IDX;
          end else if (broadcast_select_bit) begin
            need_idx_q <= 1'b1;
            state_q <= S_IDX;
          end else
            state_q <= S_NXT;
        end
        S_IDX: begin // words 3 and 4 always pass by on the way to word 5
          rsel_q <= `BSS_RD_IDX;
          rd_req_q <= 1'b1;
          rd_addr_q <= addr_q;
          state_q <= S_RD;
        end
        S_PUSH: if (!tail_v_q) state_q <= S_NXT;
        S_NXT: begin // checked after every beacon record, accepted or rejected
          if (ovf_q) begin
            rsel_q <= `BSS_RD_PAGE;
            rd_req_q <= 1'b1;
            rd_addr_q <= addr_q;
            state_q <= S_RD;
          end else if (irq_pend) begin
            if (cnt_q != 16'h0000 && !irq_program) begin
              addr_q <= addr_q - `BSS_DW_STEP;
              instruction_counter <= instruction_counter - `BSS_CTR_BACK;
            end
            state_q <= S_REST;
          end else if (cnt_q == 16'h0000) begin
            state_q <= S_REST;
          end else begin
            rsel_q <= `BSS_RD_HDR;
            rd_req_q <= 1'b1;
            rd_addr_q <= addr_q;
            state_q <= S_RD;
          end
        end
        S_REST: begin
          rsel_q <= `BSS_RD_REST;
          rd_req_q <= 1'b1;
          rd_addr_q <= base_q + `BSS_WORK_OFS;
          state_q <= S_RD;
        end
        S_ST1: begin
          if (st_ack) begin
            st_addr_q <= base_q + `BSS_K_OFS;
            st_data_q <= k_data;
            state_q <= S_ST2;
          end
        end
        S_ST2: begin
          if (st_ack) begin
            st_req_q <= 1'b0;
            state_q <= S_FIN;
          end
        end
        S_FIN: begin // final writeback and condition code
          busy_q <= 1'b0;
          done_q <= 1'b1;
          gpr_wr_q <= 1'b1;
          gpr8_q <= {g8_hi_q & ~(`BSS_STORED_MASK | `BSS_RW_MASK), base_q};
          gpr9_q <= {g9_hi_q[7:4], ovf_end_q ? ovf_bin_q : g9_hi_q[3:0],
                     addr_q - `BSS_DW_STEP};
          if (bad_q) cc_q <= `BSS_CC_BADHDR;
          else if (ovf_end_q) cc_q <= `BSS_CC_OVF;
          else if (|(g8_hi_q & `BSS_STORED_MASK)) cc_q <= `BSS_CC_DATA;
          else cc_q <= `BSS_CC_NONE;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// File: bss_regs.vh
// constants for the beacon sort-select and termination sequencer
`ifndef BSS_REGS_VH
`define BSS_REGS_VH
`define BSS_R1_BEACON   4'h2
`define BSS_CC_NONE     2'h0
`define BSS_CC_DATA     2'h1
`define BSS_CC_OVF      2'h2
`define BSS_CC_BADHDR   2'h3
`define BSS_DW_STEP     24'h000008
`define BSS_WORK_OFS    24'h000008
`define BSS_K_OFS       24'h00000c
`define BSS_CTR_BACK    24'h000002
`define BSS_BCAST_POS   5'd20
`define BSS_STORED_MASK 8'hf0
`define BSS_RW_MASK     8'h08
`define BSS_RD_HDR      3'h0
`define BSS_RD_IDX      3'h1
`define BSS_RD_CRD      3'h2
`define BSS_RD_PAGE     3'h3
`define BSS_RD_REST     3'h4
`endif

// File: bss_storage_model.sv
// main storage model: answers reads and stores after a random delay
`timescale 1ns/1ns
module bss_storage_model (
  // clock and reset
  input  wire         sys_clk,
  input  wire         rst,
  // read port
  input  wire         rd_req_q,
  input  wire  [23:0] rd_addr_q,
  output logic        rd_ack,
  output logic [63:0] rd_data,
  // store port
  input  wire         st_req_q,
  input  wire  [23:0] st_addr_q,
  input  wire  [31:0] st_data_q,
  output logic        st_ack
);
  logic [63:0] mem [0:31];
  logic [55:0] st_q [$];
  int          dly;
  // one ack per request; idle data is inverted so nothing may rest on it
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_ack <= 1'b0;
      st_ack <= 1'b0;
      rd_data <= 64'h0;
      dly <= 0;
    end else begin
      rd_ack <= 1'b0;
      st_ack <= 1'b0;
      rd_data <= ~rd_data;
      if ((rd_req_q && !rd_ack) || (st_req_q && !st_ack)) begin
        if (dly == 0) begin
          dly <= $urandom_range(3);
          if (rd_req_q && !rd_ack) begin
            rd_ack <= 1'b1;
            rd_data <= mem[rd_addr_q[7:3]];
          end else begin
            st_ack <= 1'b1;
            st_q.push_back({st_addr_q, st_data_q});
          end
        end else begin
          dly <= dly - 1;
        end
      end
    end
  end
endmodule

// File: bss_sort_select_checker.sv
// assertions on the sort-select sequencer ports
`timescale 1ns/1ns
module bss_sort_select_checker (
  // clock and reset
  input wire        sys_clk,
  input wire        rst,
  // start
  input wire        start,
  input wire [3:0]  r1_field,
  input wire [31:0] gpr9_in,
  // storage and filter
  input wire        rd_req_q,
  input wire [23:0] rd_addr_q,
  input wire        rd_ack,
  input wire        st_req_q,
  input wire [23:0] st_addr_q,
  input wire [31:0] st_data_q,
  input wire        st_ack,
  input wire        fl_valid_q,
  input wire [31:0] fl_data_q,
  input wire        fl_ready,
  // results
  input wire        busy_q,
  input wire        done_q,
  input wire        gpr_wr_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_take;
    start && !busy_q && r1_field == 4'h2;
  endsequence
  sequence s_rd_wait;
    rd_req_q && !rd_ack;
  endsequence
  a_first_read: assert property (s_take |=> rd_req_q && rd_addr_q == $past(gpr9_in[23:0]))
    else $error("first read not at input address");
  a_refuse_other: assert property (start && !busy_q && r1_field != 4'h2 |=> !busy_q)
    else $error("start taken with wrong field");
  a_rd_stand: assert property (s_rd_wait |=> rd_req_q && $stable(rd_addr_q))
    else $error("read request dropped early");
  a_st_stand: assert property (st_req_q && !st_ack |=> st_req_q && $stable(st_data_q))
    else $error("store request dropped early");
  a_st_addr: assert property (st_req_q && !st_ack |=> $stable(st_addr_q))
    else $error("store address moved");
  a_fl_stand: assert property (fl_valid_q && !fl_ready |=> fl_valid_q && $stable(fl_data_q))
    else $error("filter word dropped early");
  a_done_once: assert property (done_q |=> !done_q)
    else $error("done longer than one cycle");
  a_done_write: assert property (done_q |-> gpr_wr_q)
    else $error("registers not written at end");
  a_idle_quiet: assert property (!busy_q && !done_q |-> !rd_req_q && !st_req_q)
    else $error("storage request while idle");
endmodule
bind bss_sort_select bss_sort_select_checker i_chk (.sys_clk, .rst, .start, .r1_field, .gpr9_in,
  .rd_req_q, .rd_addr_q, .rd_ack, .st_req_q, .st_addr_q, .st_data_q, .st_ack, .fl_valid_q,
  .fl_data_q, .fl_ready, .busy_q, .done_q, .gpr_wr_q);

// File: tb.sv
// self-checking bench for the beacon sort-select sequencer
`timescale 1ns/1ns
`include "bss_regs.vh"
module tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic        irq_pend = 1'b0;
  logic        irq_program = 1'b0;
  logic        bin_ovf = 1'b0;
  logic        fl_ready = 1'b0;
  logic [3:0]  r1_field = 4'h0;
  logic [3:0]  bin_num = 4'h0;
  logic [23:0] instr_counter_in = 24'h0;
  logic [31:0] gpr8_in = 32'h0, gpr9_in = 32'h0, gpr10_in = 32'h0, gpr11_in = 32'h0;
  logic [31:0] k_data = 32'h0;
  wire         rd_req_q, rd_ack, st_req_q, st_ack, fl_valid_q, busy_q, done_q, gpr_wr_q;
  wire  [23:0] rd_addr_q, st_addr_q, instruction_counter;
  wire  [63:0] rd_data;
  wire  [31:0] st_data_q, fl_data_q, header_hold_register, gpr8_q, gpr9_q, gpr12_q, gpr13_q;
  wire  [1:0]  cc_q;
  int          bad_count = 0;
  int          checks = 0;
  logic        timed_out = 1'b0;
  logic [31:0] fl_q [$];

  bss_sort_select i_bss_sort_select (.sys_clk, .rst, .start, .r1_field, .instr_counter_in,
    .gpr8_in, .gpr9_in, .gpr10_in, .gpr11_in, .k_data, .irq_pend, .irq_program, .bin_ovf,
    .bin_num, .rd_req_q, .rd_addr_q, .rd_ack, .rd_data, .st_req_q, .st_addr_q, .st_data_q,
    .st_ack, .fl_valid_q, .fl_data_q, .fl_ready, .busy_q, .done_q, .cc_q, .header_hold_register,
    .gpr8_q, .gpr9_q, .gpr12_q, .gpr13_q, .instruction_counter, .gpr_wr_q);
  bss_storage_model i_bss_storage_model (.sys_clk, .rst, .rd_req_q, .rd_addr_q, .rd_ack,
    .rd_data, .st_req_q, .st_addr_q, .st_data_q, .st_ack);

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial forever #5 sys_clk = ~sys_clk;
  // filter side stalls at random and logs every word it takes
  always @(posedge sys_clk) begin
    fl_ready <= $urandom_range(1);
    if (fl_valid_q && fl_ready) fl_q.push_back(fl_data_q);
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // modes: 0 plain, 1 program irq, 2 i/o irq, 3 overflow, 4 bad header, 5 refused
  task automatic run(input int mode);
    logic [31:0] h, s, w[2:5], g8, g11;
    logic [63:0] m17;
    logic        ok;
    int          n, i, ix;
    h = $urandom;
    g11 = $urandom;
    g8 = {8'($urandom), 24'h000180};
    foreach (w[j]) w[j] = $urandom;
    m17 = {$urandom, $urandom};
    h[31] = (mode != 4);
    if ($urandom_range(3) == 0) h[15:8] = g11[23:16];
    case (g11[30:29])
      2'h0: s = w[2];
      2'h1: s = w[3];
      default: s = w[4];
    endcase
    ix = 31 - 8 * g11[28:27] - g11[26:24];
    ok = h[15:8] == g11[23:16] || |(h[23:21] & g11[15:13]) || (h[11] && s[ix]);
    n = ok ? 3 : (h[11] ? 2 : 1);
    if (mode == 4) n = 1;
    i_bss_storage_model.mem[0] = {h, w[2]};
    i_bss_storage_model.mem[1] = {w[3], w[4]};
    i_bss_storage_model.mem[2] = {w[5], ~w[5]};
    i_bss_storage_model.mem[3] = {~h, ~w[2]};
    i_bss_storage_model.mem[17] = m17;
    i_bss_storage_model.st_q.delete();
    fl_q.delete();
    @(posedge sys_clk);
    r1_field <= (mode == 5) ? 4'h0 : `BSS_R1_BEACON;
    gpr8_in <= g8;
    gpr9_in <= {8'($urandom), 24'h000100};
    gpr10_in <= n + (mode == 1 || mode == 2) + 2 * (mode == 3);
    gpr11_in <= g11;
    k_data <= $urandom;
    instr_counter_in <= $urandom;
    irq_pend <= (mode == 1 || mode == 2);
    irq_program <= (mode == 1);
    bin_num <= $urandom;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    bin_ovf <= (mode == 3);
    @(posedge sys_clk);
    bin_ovf <= 1'b0;
    if (mode == 5) begin
      #1 chk(busy_q, 0);
      return;
    end
    for (i = 0; i < 3000 && done_q !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (i == 3000) begin
      bad_count++;
      timed_out = 1'b1;
      return;
    end
    chk(cc_q, mode == 4 ? 3 : mode == 3 ? 2 : (|gpr8_in[31:28] ? 1 : 0));
    if (mode == 4) begin
      chk(i_bss_storage_model.st_q.size(), 0);
      return;
    end
    chk(header_hold_register, h);
    chk(gpr8_q, {g8[31:24] & 8'h07, g8[23:0]});
    chk(gpr9_q[27:24], mode == 3 ? bin_num : gpr9_in[27:24]);
    chk(gpr9_q[23:0], gpr9_in[23:0] + 8 * (n - 1 - (mode == 2) + (mode == 3)));
    chk(instruction_counter, 24'(instr_counter_in - 24'h2 * (mode == 2)));
    chk({gpr12_q, gpr13_q}, m17);
    // a stalled filter may still hold the word when the run ends
    for (i = 0; i < 100 && fl_valid_q !== 1'b0; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(fl_q.size(), ok);
    if (ok) chk(fl_q[0], w[5]);
    chk(i_bss_storage_model.st_q.size(), 2);
    chk(i_bss_storage_model.st_q[0], {g8[23:0] + 24'h8, h});
    chk(i_bss_storage_model.st_q[1], {g8[23:0] + 24'hc, k_data});
  endtask

  // main sequence
  initial begin
    void'($urandom(32'h54e6));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    for (int t = 0; t < 60 && !timed_out; t++) run(t % 6);
    give_verdict();
  end
endmodule
